// ===== verilog/bls_boot_loader.sv
// Tile boot sequencer: security load, image parse, CRC check, security gates.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module bls_boot_loader #(
  parameter int BOOT_DELAY = bls_pkg::BOOT_DELAY_CYC,
  parameter int RAM_AW = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic [31:0] gpio_pulldown,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic flash_req,
  input wire logic flash_valid,
  input wire logic [7:0] flash_byte,
  output logic ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  output logic cpu_start,
  output logic [31:0] cpu_pc,
  output logic boot_fail,
  input wire logic jtag_tile_req,
  output logic jtag_tile_grant,
  input wire logic jtag_otp_req,
  output logic jtag_otp_grant,
  input wire logic link_req,
  output logic link_grant,
  input wire logic debug_in,
  output logic debug_enter,
  output logic otp_redundant_en,
  output logic [9:0] user_code_extension
);
  initial begin
    if (BOOT_DELAY < 1 || RAM_AW < 2 || RAM_AW > 30) begin
      $error("BOOT_DELAY or RAM_AW out of range");
    end
  end

  typedef enum logic [7:0] {
    BLS_RESET = 8'h01,
    BLS_SEC = 8'h02,
    BLS_WAIT = 8'h04,
    BLS_COUNT = 8'h08,
    BLS_PROG = 8'h10,
    BLS_TRAIL = 8'h20,
    BLS_RUN = 8'h40,
    BLS_FAIL = 8'h80
  } bls_state_t;

  bls_state_t state_q;
  logic [31:0] sec_q;
  logic [31:0] dly_q;
  logic [31:0] word_q;
  logic [1:0] bcnt_q;
  logic [31:0] words_q;
  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic [10:0] otp_rd_q;
  logic [31:0] otp_rdata;
  logic otp_src_q;
  logic sec_loaded_q;
  logic [15:0] otp_addr_q;
  logic [31:0] otp_data_q;
  logic [15:0] otp_ctrl_q;
  logic prog_refused_q;
  logic otp_wr;
  logic otp_pend_q;
  logic byte_v;
  logic [7:0] byte_in;
  logic [31:0] word_nx;
  logic [1:0] otp_sub_q;

  // Security bit test used by every access gate.
  function automatic logic sec_bit(input logic [31:0] s, input int pos);
    return s[pos];
  endfunction

  // GPIO pull-downs stand while the chip is in reset and until the first clock edge after it; async set covers it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_pulldown <= 32'hffffffff;
    end else begin
      gpio_pulldown <= 32'h00000000;
    end
  end

  bls_otp_mem #(
    .SECTORS(bls_pkg::OTP_SECTORS),
    .ROWS(bls_pkg::OTP_ROWS)
  ) u_otp (
    .clk(clk),
    .rd_addr(otp_rd_q),
    .rd_data(otp_rdata),
    .wr_en(otp_wr),
    .wr_addr(otp_addr_q[10:0]),
    .wr_data(otp_data_q)
  );

  // OTP source delivers four bytes per row, one per cycle after a one-cycle read wait, least significant byte first.
  always_comb begin
    if (otp_src_q) begin
      byte_v = otp_pend_q;
      byte_in = otp_rdata[8*otp_sub_q +: 8];
    end else begin
      byte_v = flash_valid;
      byte_in = flash_byte;
    end
    word_nx = {byte_in, word_q[31:8]};
  end

  bls_crc32 u_crc (
    .crc_in(crc_q),
    .data(byte_in),
    .crc_out(crc_d)
  );

  assign flash_req = !otp_src_q && (state_q == BLS_COUNT || state_q == BLS_PROG ||
    state_q == BLS_TRAIL);

  // Boot sequencer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= BLS_RESET;
      dly_q <= 32'h00000000;
      word_q <= 32'h00000000;
      bcnt_q <= 2'h0;
      words_q <= 32'h00000000;
      crc_q <= bls_pkg::CRC_INIT;
      otp_src_q <= 1'b0;
      otp_rd_q <= bls_pkg::OTP_SEC_ROW;
      otp_sub_q <= 2'h0;
      otp_pend_q <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= '0;
      ram_wdata <= 32'h00000000;
      cpu_start <= 1'b0;
      cpu_pc <= 32'h00000000;
      boot_fail <= 1'b0;
    end else begin
      ram_we <= 1'b0;
      case (state_q)
        BLS_RESET: begin
          otp_rd_q <= bls_pkg::OTP_SEC_ROW;
          state_q <= BLS_SEC;
        end
        BLS_SEC: begin
          state_q <= BLS_WAIT;
        end
        BLS_WAIT: begin
          dly_q <= dly_q + 32'h00000001;
          if (sec_loaded_q && dly_q >= 32'(BOOT_DELAY - 1)) begin
            otp_src_q <= sec_bit(sec_q, bls_pkg::SEC_SECURE_BOOT);
            otp_rd_q <= 11'h000;
            otp_sub_q <= 2'h0;
            otp_pend_q <= 1'b0;
            crc_q <= bls_pkg::CRC_INIT;
            bcnt_q <= 2'h0;
            state_q <= BLS_COUNT;
          end
        end
        BLS_COUNT, BLS_PROG, BLS_TRAIL: begin
          if (otp_src_q) begin
            // The OTP read has one cycle of latency; bytes follow from the held row.
            if (!otp_pend_q) begin
              otp_pend_q <= 1'b1;
            end else begin
              otp_sub_q <= otp_sub_q + 2'h1;
              if (otp_sub_q == 2'h3) begin
                otp_rd_q <= otp_rd_q + 11'h001;
                otp_pend_q <= 1'b0;
              end
            end
          end
          if (byte_v) begin
            word_q <= word_nx;
            bcnt_q <= bcnt_q + 2'h1;
            if (state_q != BLS_TRAIL) begin
              crc_q <= crc_d;
            end
            if (bcnt_q == 2'h3) begin
              case (state_q)
                BLS_COUNT: begin
                  words_q <= word_nx;
                  state_q <= (word_nx == 32'h00000000) ? BLS_TRAIL : BLS_PROG;
                end
                BLS_PROG: begin
                  ram_we <= 1'b1;
                  ram_wdata <= word_nx;
                  ram_addr <= ram_addr + 1'b1;
                  words_q <= words_q - 32'h00000001;
                  if (words_q == 32'h00000001) begin
                    state_q <= BLS_TRAIL;
                  end
                end
                default: begin
                  if (word_nx == bls_pkg::SKIP_MARKER || word_nx == ~crc_q) begin
                    cpu_start <= 1'b1;
                    cpu_pc <= 32'h00000000;
                    state_q <= BLS_RUN;
                  end else begin
                    boot_fail <= 1'b1;
                    state_q <= BLS_FAIL;
                  end
                end
              endcase
            end
          end
        end
        BLS_RUN: begin
          cpu_start <= 1'b0;
        end
        BLS_FAIL: begin
          state_q <= BLS_FAIL;
        end
        default: begin
          state_q <= BLS_RESET;
        end
      endcase
      // The first word lands at address zero: the increment is pre-biased.
      if (state_q == BLS_WAIT) begin
        ram_addr <= '1;
      end
    end
  end

  // Security register: OTP copy at power-up, then only the general field is soft.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sec_q <= bls_pkg::SEC_RESET;
      sec_loaded_q <= 1'b0;
    end else if (state_q == BLS_SEC) begin
      sec_q <= otp_rdata;
      sec_loaded_q <= 1'b1;
    end else if (reg_wr && reg_addr == bls_pkg::REG_SECURITY) begin
      sec_q[bls_pkg::SEC_GP_HI:bls_pkg::SEC_GP_LO] <=
        reg_wdata[bls_pkg::SEC_GP_HI:bls_pkg::SEC_GP_LO];
    end
  end

  // OTP programming port registers and the write gate.
  logic prog_go;
  logic sector_locked;
  assign prog_go = reg_wr && reg_addr == bls_pkg::REG_OTP_CTRL &&
    (reg_wdata[15:0] & bls_pkg::OTP_CTRL_PROG) != 16'h0000;
  assign sector_locked = sec_q[bls_pkg::SEC_LOCK_LO + otp_addr_q[10:9]];
  assign otp_wr = prog_go && sec_loaded_q && !sector_locked &&
    !sec_bit(sec_q, bls_pkg::SEC_MASTER_LOCK);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      otp_addr_q <= 16'h0000;
      otp_data_q <= 32'h00000000;
      otp_ctrl_q <= 16'h0000;
      prog_refused_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == bls_pkg::REG_OTP_ADDR) begin
        otp_addr_q <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == bls_pkg::REG_OTP_DATA) begin
        otp_data_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == bls_pkg::REG_OTP_CTRL) begin
        otp_ctrl_q <= reg_wdata[15:0];
      end
      // A refusal in the same cycle as a clear wins.
      if (prog_go && !otp_wr) begin
        prog_refused_q <= 1'b1;
      end else if (reg_wr && reg_addr == bls_pkg::REG_STATUS &&
        reg_wdata[bls_pkg::ST_PROG_REFUSED]) begin
        prog_refused_q <= 1'b0;
      end
    end
  end

  // Access gates; nothing is granted before the security copy is in place.
  always_comb begin
    jtag_tile_grant = jtag_tile_req && sec_loaded_q &&
      !sec_bit(sec_q, bls_pkg::SEC_JTAG_OFF);
    jtag_otp_grant = jtag_otp_req && sec_loaded_q &&
      !sec_bit(sec_q, bls_pkg::SEC_JTAG_OFF) &&
      !sec_bit(sec_q, bls_pkg::SEC_JTAG_OTP_OFF);
    link_grant = link_req && sec_loaded_q &&
      !sec_bit(sec_q, bls_pkg::SEC_LINK_OFF);
    debug_enter = !debug_in && sec_loaded_q &&
      !sec_bit(sec_q, bls_pkg::SEC_DEBUG_OFF);
    otp_redundant_en = sec_bit(sec_q, bls_pkg::SEC_REDUNDANT);
    user_code_extension = sec_q[bls_pkg::SEC_UC_HI:bls_pkg::SEC_UC_LO];
  end

  // Read port: data stands in the cycle after the strobe only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        bls_pkg::REG_SECURITY: reg_rdata <= sec_q;
        bls_pkg::REG_STATUS: reg_rdata <= {28'h0000000, prog_refused_q,
          state_q == BLS_RUN, boot_fail, state_q == BLS_RUN};
        bls_pkg::REG_CRC: reg_rdata <= ~crc_q;
        bls_pkg::REG_OTP_ADDR: reg_rdata <= {16'h0000, otp_addr_q};
        bls_pkg::REG_OTP_DATA: reg_rdata <= otp_data_q;
        bls_pkg::REG_OTP_CTRL: reg_rdata <= {16'h0000, otp_ctrl_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  chk_jtag_block: assert property (@(posedge clk) disable iff (!rst_b)
    sec_q[bls_pkg::SEC_JTAG_OFF] |-> !jtag_tile_grant && !jtag_otp_grant)
    else $error("JTAG granted while disabled");
  chk_link_block: assert property (@(posedge clk) disable iff (!rst_b)
    (link_req && !sec_q[bls_pkg::SEC_LINK_OFF] && sec_loaded_q) |-> link_grant)
    else $error("link access wrongly gated");
  chk_master_lock: assert property (@(posedge clk) disable iff (!rst_b)
    sec_q[bls_pkg::SEC_MASTER_LOCK] |-> !otp_wr)
    else $error("OTP written under master lock");
  chk_sector_lock: assert property (@(posedge clk) disable iff (!rst_b)
    (otp_wr) |-> !sec_q[bls_pkg::SEC_LOCK_LO + otp_addr_q[10:9]])
    else $error("locked sector programmed");
  chk_debug_gate: assert property (@(posedge clk) disable iff (!rst_b)
    sec_q[bls_pkg::SEC_DEBUG_OFF] |-> !debug_enter)
    else $error("debug pin active while disabled");
  chk_boot_delay: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == BLS_COUNT && $past(state_q) == BLS_WAIT) |-> dly_q >= 32'(BOOT_DELAY))
    else $error("boot began before internal reset delay");
  chk_start_pc: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cpu_start) |-> cpu_pc == 32'h00000000 ##1 !cpu_start)
    else $error("start not a single pulse at address zero");
  chk_fail_hold: assert property (@(posedge clk) disable iff (!rst_b)
    boot_fail |-> !cpu_start ##1 (boot_fail && !cpu_start))
    else $error("program started after boot failure");
  chk_sec_source: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == BLS_COUNT && $past(state_q) == BLS_WAIT) |->
      otp_src_q == sec_q[bls_pkg::SEC_SECURE_BOOT])
    else $error("boot source does not follow secure bit");
endmodule // bls_boot_loader

// ===== verilog/bls_pkg.sv
// Package with constants shared by the boot image loader and security block.
package bls_pkg;
  // Reset-to-boot delay.
  localparam int BOOT_DELAY_MIN_US = 15;
  localparam int BOOT_DELAY_MAX_US = 150;
  localparam int CLK_MHZ = 100;
  localparam int BOOT_DELAY_CYC = BOOT_DELAY_MIN_US * CLK_MHZ;
  // Boot image.
  localparam logic [31:0] SKIP_MARKER = 32'h0d15ab1e;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  // OTP geometry.
  localparam int OTP_SECTORS = 4;
  localparam int OTP_ROWS = 512;
  localparam int OTP_WIDTH = 32;
  localparam int OTP_AW = 11;
  localparam logic [10:0] OTP_SEC_ROW = 11'h7ff;
  // Security register field positions.
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_LINK_OFF = 1;
  localparam int SEC_SECURE_BOOT = 5;
  localparam int SEC_REDUNDANT = 7;
  localparam int SEC_LOCK_LO = 8;
  localparam int SEC_MASTER_LOCK = 12;
  localparam int SEC_JTAG_OTP_OFF = 13;
  localparam int SEC_DEBUG_OFF = 14;
  localparam int SEC_GP_LO = 15;
  localparam int SEC_GP_HI = 21;
  localparam int SEC_UC_LO = 22;
  localparam int SEC_UC_HI = 31;
  localparam logic [31:0] SEC_RESET = 32'h00000000;
  // OTP programming port identifiers.
  localparam logic [23:0] OTP_ADDR_PORT_ID = 24'h100200;
  localparam logic [23:0] OTP_DATA_PORT_ID = 24'h200100;
  localparam logic [23:0] OTP_CTRL_PORT_ID = 24'h100300;
  // Register map of the plain port.
  localparam logic [3:0] REG_SECURITY = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CRC = 4'h2;
  localparam logic [3:0] REG_OTP_ADDR = 4'h3;
  localparam logic [3:0] REG_OTP_DATA = 4'h4;
  localparam logic [3:0] REG_OTP_CTRL = 4'h5;
  localparam int ST_DONE = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_RUN = 2;
  localparam int ST_PROG_REFUSED = 3;
  localparam logic [15:0] OTP_CTRL_PROG = 16'h0001;
endpackage

// ===== verilog/bls_crc32.sv
// Byte-wise reflected CRC-32 update step.
`timescale 1ns/1ps
module bls_crc32 (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data,
  output logic [31:0] crc_out
);
  always_comb begin
    logic [31:0] c;
    c = crc_in ^ {24'h000000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ bls_pkg::CRC_POLY) : (c >> 1);
    end
    crc_out = c;
  end
endmodule // bls_crc32

// ===== verilog/bls_otp_mem.sv
// OTP array of four sectors with a program port and a read port.
`timescale 1ns/1ps
module bls_otp_mem #(
  parameter int SECTORS = bls_pkg::OTP_SECTORS,
  parameter int ROWS = bls_pkg::OTP_ROWS
) (
  input wire logic clk,
  input wire logic [10:0] rd_addr,
  output logic [31:0] rd_data,
  input wire logic wr_en,
  input wire logic [10:0] wr_addr,
  input wire logic [31:0] wr_data
);
  initial begin
    if (SECTORS * ROWS != 2048) begin
      $error("OTP geometry must span an 11-bit address");
    end
  end
  // Unprogrammed cells read as zero; programming can only set bits.
  logic [31:0] mem [0:SECTORS*ROWS-1] = '{default: 32'h00000000};
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= mem[wr_addr] | wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // bls_otp_mem

// ===== test/bls_flash_model.sv
// Behavioural model of the boot flash that streams the image one byte at a time.
`timescale 1ns/1ps
module bls_flash_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flash_req,
  input wire logic slow,
  output logic flash_valid,
  output logic [7:0] flash_byte
);
  logic [31:0] img_w [0:63];
  int len_b;
  int pos;
  int nxt;
  // An idle byte lane toggles so that a loader sampling it without valid picks up garbage.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos <= 0;
      flash_valid <= 1'b0;
      flash_byte <= 8'h5a;
    end else begin
      nxt = pos + ((flash_valid && flash_req) ? 1 : 0);
      pos <= nxt;
      if (flash_req && nxt < len_b && (!slow || $urandom_range(0, 1) == 1)) begin
        flash_valid <= 1'b1;
        flash_byte <= img_w[nxt / 4][8 * (nxt % 4) +: 8];
      end else begin
        flash_valid <= 1'b0;
        flash_byte <= ~flash_byte;
      end
    end
  end
endmodule // bls_flash_model

// ===== test/boot_image_loader_security_tb_top.sv
// Self-checking testbench for the boot loader with its security gates.
`timescale 1ns/1ps
module boot_image_loader_security_tb_top;
  localparam int BD = 4;
  localparam logic [31:0] S1 = 32'ha94061a3;
  logic clk, rst_b, reg_wr, reg_rd, flash_valid, ram_we, cpu_start, boot_fail, flash_req;
  logic jtag_tile_req, jtag_tile_grant, jtag_otp_req, jtag_otp_grant, link_req, link_grant;
  logic debug_in, debug_enter, otp_redundant_en, slow, otp_mode, exp_ok;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, gpio_pulldown, ram_wdata, cpu_pc, exp_crc, d;
  logic [7:0] flash_byte;
  logic [15:0] ram_addr;
  logic [9:0] user_code_extension;
  logic [31:0] iw[$];
  int n_fail, check_count, n_start, nw, exp_cnt;

  bls_boot_loader #(.BOOT_DELAY(BD)) DUT (.clk, .rst_b, .gpio_pulldown, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_req, .flash_valid, .flash_byte,
    .ram_we, .ram_addr, .ram_wdata, .cpu_start, .cpu_pc, .boot_fail, .jtag_tile_req,
    .jtag_tile_grant, .jtag_otp_req, .jtag_otp_grant, .link_req, .link_grant, .debug_in,
    .debug_enter, .otp_redundant_en, .user_code_extension);
  bls_flash_model flash (.clk, .rst_b, .flash_req, .slow, .flash_valid, .flash_byte);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ bls_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction

  // Mode 0 carries the right CRC, 1 the skip marker, 2 a corrupted CRC.
  task automatic make_image(input int cnt, input int mode);
    logic [31:0] c;
    iw.delete();
    iw.push_back(cnt);
    for (int i = 0; i < cnt; i++)
      iw.push_back($urandom);
    c = bls_pkg::CRC_INIT;
    foreach (iw[k])
      for (int j = 0; j < 4; j++)
        c = crc_byte(c, iw[k][8 * j +: 8]);
    exp_crc = ~c;
    iw.push_back(mode == 0 ? ~c : (mode == 1 ? bls_pkg::SKIP_MARKER : ~c ^ 32'h1));
    exp_cnt = cnt;
    exp_ok = (mode != 2);
    foreach (iw[k])
      flash.img_w[k] = iw[k];
    flash.len_b = 4 * iw.size();
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic otp_prog(input logic [10:0] a, input logic [31:0] v);
    reg_write(bls_pkg::REG_OTP_ADDR, {21'h0, a});
    reg_write(bls_pkg::REG_OTP_DATA, v);
    reg_write(bls_pkg::REG_OTP_CTRL, {16'h0, bls_pkg::OTP_CTRL_PROG});
  endtask

  task automatic do_reset(input logic from_flash);
    int k;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check(gpio_pulldown, 32'hffffffff);
    @(posedge clk);
    rst_b <= 1'b1;
    n_start = 0;
    nw = 0;
    @(posedge clk);
    #1;
    check(gpio_pulldown, 32'h0);
    if (from_flash) begin
      k = 1;
      // The request is looked at after each edge, once it has settled.
      while (flash_req !== 1'b1 && k < 50) begin
        @(posedge clk);
        #1;
        k++;
      end
      check(k >= BD && k <= BD + 6, 1'b1);
    end
  endtask

  task automatic wait_boot();
    int k;
    k = 0;
    while (n_start == 0 && boot_fail !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      n_fail++;
      $display("Error at %0t: boot never ended", $time);
      finish_test();
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic post_check();
    check(nw, exp_cnt);
    check(n_start, exp_ok);
    check(boot_fail, !exp_ok);
    reg_read(bls_pkg::REG_STATUS, d);
    check(d[2:0], {exp_ok, !exp_ok, exp_ok});
    reg_read(bls_pkg::REG_CRC, d);
    check(d, exp_crc);
  endtask

  task automatic gates(input logic blk);
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      jtag_tile_req <= r[0];
      jtag_otp_req <= r[0];
      link_req <= r[0];
      debug_in <= !r[0];
      @(posedge clk);
      #1;
      check(jtag_tile_grant, r[0] & !blk);
      check(link_grant, r[0] & !blk);
      check(jtag_otp_grant, r[0] & !blk);
      check(debug_enter, r[0] & !blk);
      check(otp_redundant_en, blk);
      check(user_code_extension, blk ? 10'h2a5 : 10'h0);
    end
  endtask

  // Every RAM write is compared with the image word it should carry, in order.
  always @(posedge clk) begin
    if (rst_b) begin
      if (ram_we) begin
        check({16'h0, ram_addr}, nw);
        check(ram_wdata, iw[nw + 1]);
        nw++;
      end
      if (cpu_start) begin
        n_start++;
        check(cpu_pc, 32'h0);
      end
      if (otp_mode)
        check(flash_req, 1'b0);
    end
  end

  initial begin
    {rst_b, reg_wr, reg_rd, slow, otp_mode, jtag_tile_req, jtag_otp_req, link_req} = '0;
    debug_in = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    n_fail = 0;
    check_count = 0;
    void'($urandom(32'hdc49));
    for (int t = 0; t < 6; t++) begin
      make_image(t == 0 ? 0 : $urandom_range(1, 8), t % 3);
      slow <= t[0];
      do_reset(1'b1);
      wait_boot();
      post_check();
    end
    gates(1'b0);
    reg_read(4'hf, d);
    check(d, 32'h0);
    reg_write(bls_pkg::REG_SECURITY, 32'hffffffff);
    reg_read(bls_pkg::REG_SECURITY, d);
    check(d, 32'h003f8000);
    // The image goes into OTP first because the secure-boot word locks sector 0, where it sits, later.
    make_image(2, 0);
    foreach (iw[k])
      otp_prog(k[10:0], iw[k]);
    otp_prog(11'h7ff, S1);
    reg_read(bls_pkg::REG_OTP_ADDR, d);
    check(d, 32'h000007ff);
    reg_read(bls_pkg::REG_OTP_DATA, d);
    check(d, S1);
    reg_read(bls_pkg::REG_OTP_CTRL, d);
    check(d, {16'h0, bls_pkg::OTP_CTRL_PROG});
    reg_read(bls_pkg::REG_STATUS, d);
    check(d[3], 1'b0);
    otp_mode = 1'b1;
    do_reset(1'b0);
    wait_boot();
    post_check();
    reg_read(bls_pkg::REG_SECURITY, d);
    check(d, S1);
    gates(1'b1);
    otp_prog(11'h000, 32'h1);
    reg_read(bls_pkg::REG_STATUS, d);
    check(d[3], 1'b1);
    reg_write(bls_pkg::REG_STATUS, 32'h8);
    otp_prog(11'h200, 32'h1);
    reg_read(bls_pkg::REG_STATUS, d);
    check(d[3], 1'b0);
    otp_prog(11'h7ff, 32'h1000);
    do_reset(1'b0);
    wait_boot();
    post_check();
    reg_read(bls_pkg::REG_SECURITY, d);
    check(d, S1 | 32'h1000);
    otp_prog(11'h200, 32'h2);
    reg_read(bls_pkg::REG_STATUS, d);
    check(d[3], 1'b1);
    finish_test();
  end
endmodule // boot_image_loader_security_tb_top
